// ==== verilog/led_ctrl_pkg.sv ====
// constants for the led fault test and broadcast control block
package led_ctrl_pkg;
    localparam int CHANNELS = 16;
    localparam logic [7:0] ADDR_CH_DUTY0 = 8'h08;
    localparam logic [7:0] ADDR_CH_GAIN0 = 8'h22;
    localparam logic [7:0] ADDR_DRIVE_MODE0 = 8'h02;
    localparam logic [7:0] ADDR_FIRST_MODE = 8'h00;
    localparam logic [7:0] ADDR_SECOND_MODE = 8'h01;
    localparam logic [7:0] ADDR_BCAST_ADDR = 8'h3E;
    localparam logic [7:0] ADDR_BCAST_DUTY = 8'h42;
    localparam logic [7:0] ADDR_BCAST_GAIN = 8'h43;
    localparam logic [7:0] ADDR_FLAGS_LOW = 8'h44;
    localparam logic [7:0] ADDR_FLAGS_HIGH = 8'h45;
    localparam int BIT_BCAST_ACK = 0;
    localparam int BIT_FAULT_TEST = 6;
    localparam int BIT_THERMAL = 7;
    localparam logic [7:0] FIRST_MODE_RESET = 8'h01;
    localparam logic [7:0] BCAST_ADDR_RESET = 8'hE0;
    localparam logic [1:0] DRIVE_OFF = 2'b00;
    localparam int CLK_MHZ = 20;
    localparam int TEST_TOTAL_NS = 52000;
    localparam int TEST_STEP_NS = 1250;
    localparam int STEP_CYCLES = TEST_STEP_NS * CLK_MHZ / 1000;
    localparam int TOTAL_CYCLES = TEST_TOTAL_NS * CLK_MHZ / 1000;
    localparam int PWM_PERIOD_NS = 32000;
    localparam int PWM_PERIOD_CYCLES = PWM_PERIOD_NS * CLK_MHZ / 1000;
endpackage : led_ctrl_pkg

// ==== verilog/led_fault_test_and_broadcast_ctrl.sv ====
// register file, broadcast writes, fault test and thermal shutdown for the led driver
// Functional notes
// - broadcast address keeps seven upper bits; bit0 zero
// - broadcast address not acknowledged when enable zero
// - broadcast duty write loads all sixteen duties
// - single duty write overrides its channel only
// - broadcast gain write loads all sixteen gains
// - single gain write overrides its channel only
// - gain code drives output current linearly
// - writing one to test bit starts test
// - whole test finishes within 52 us
// - outputs off from start until access after finish
// - each tested channel driven 1.25 us at gain
// - only channels not in off mode tested
// - tested channel disturbed up to 32 us
// - sixteen result bits written to flag registers
// - test bit cleared when flags valid
// - low flags channels 0-7, high 8-15, read-only
// - opens present: flag opens only, else shorts
// - channels off when the test ends report zero
// - open detector sets enabled channel fault bit; flags are set only when a fault test ends
// - short detector sets bit, normal level clears; flags change only when a fault test ends
// - overtemperature disables outputs and sets bit 7
// - pwm only in drive modes 10 or 11
// - broadcast acknowledge enable resets to one
`timescale 1ns/1ps
module led_fault_test_and_broadcast_ctrl
    import led_ctrl_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    input wire logic [6:0] bus_addr,
    input wire logic bus_addr_valid,
    output logic broadcast_match,
    input wire logic [15:0] open_det,
    input wire logic [15:0] short_det,
    input wire logic thermal_shutdown_flag_det,
    output logic [15:0] chan_enable,
    output logic [15:0] chan_pwm_mode,
    output logic [15:0] chan_test_drive,
    output logic [127:0] chan_duty_bus,
    output logic [127:0] chan_gain_bus
);
    localparam int STEP_W = 6;
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYCLES - 1);

    initial begin
        if (CHANNELS != 16 || STEP_CYCLES * CHANNELS > TOTAL_CYCLES) begin
            $error("fault test timing or channel count unsupported");
        end
    end

    typedef enum logic [1:0] {IDLE, TESTING, HOLD_OFF} test_state_t;

    typedef struct packed {
        logic [127:0] duty;
        logic [127:0] gain;
        logic [31:0] drive_mode;
        logic [7:0] first_mode;
        logic [6:0] bcast_addr;
        logic test_busy;
        logic [15:0] flags;
        logic [15:0] open_acc;
        logic [15:0] short_acc;
        test_state_t st;
        logic [3:0] chan;
        logic [STEP_W-1:0] step;
        logic [1:0] ot_sync;
        logic [15:0] open_s1, open_s2, short_s1, short_s2;
        logic [7:0] rdata;
        logic match;
        logic [15:0] en;
        logic [15:0] pwm;
        logic [15:0] tdrv;
    } state_t;

    state_t s_r, s_nxt;
    logic [15:0] active_ch;
    logic thermal;

    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            active_ch[i] = s_r.drive_mode[2*i +: 2] != DRIVE_OFF;
        end
        thermal = s_r.ot_sync[1];
    end

    // next-state: register writes, test sequencing, status and outputs
    always_comb begin
        logic [3:0] idx;
        idx = 4'h0;
        s_nxt = s_r;
        // detector synchronisers; first stage is read only by the second
        s_nxt.ot_sync = {s_r.ot_sync[0], thermal_shutdown_flag_det};
        s_nxt.open_s1 = open_det;
        s_nxt.open_s2 = s_r.open_s1;
        s_nxt.short_s1 = short_det;
        s_nxt.short_s2 = s_r.short_s1;

        if (reg_wr) begin
            if (reg_addr >= ADDR_CH_DUTY0 && reg_addr < ADDR_CH_DUTY0 + 8'h10) begin
                idx = 4'(reg_addr - ADDR_CH_DUTY0);
                s_nxt.duty[8*idx +: 8] = reg_wdata;
            end
            if (reg_addr >= ADDR_CH_GAIN0 && reg_addr < ADDR_CH_GAIN0 + 8'h10) begin
                idx = 4'(reg_addr - ADDR_CH_GAIN0);
                s_nxt.gain[8*idx +: 8] = reg_wdata;
            end
            if (reg_addr >= ADDR_DRIVE_MODE0 && reg_addr < ADDR_DRIVE_MODE0 + 8'h04) begin
                idx = 4'(reg_addr - ADDR_DRIVE_MODE0);
                s_nxt.drive_mode[8*idx[1:0] +: 8] = reg_wdata;
            end
            case (reg_addr)
                ADDR_FIRST_MODE: s_nxt.first_mode = reg_wdata;
                ADDR_BCAST_ADDR: s_nxt.bcast_addr = reg_wdata[7:1];
                ADDR_BCAST_DUTY: s_nxt.duty = {CHANNELS{reg_wdata}};
                ADDR_BCAST_GAIN: s_nxt.gain = {CHANNELS{reg_wdata}};
                ADDR_SECOND_MODE: begin
                    // a start while busy is ignored; test already running
                    if (reg_wdata[BIT_FAULT_TEST] && s_r.st == IDLE) begin
                        s_nxt.test_busy = 1'b1;
                        s_nxt.st = TESTING;
                        s_nxt.chan = 4'h0;
                        s_nxt.step = '0;
                        s_nxt.open_acc = '0;
                        s_nxt.short_acc = '0;
                    end
                end
                default: ;
            endcase
        end

        // read mux; reserved and unmapped read zero
        s_nxt.rdata = 8'h00;
        if (reg_addr >= ADDR_CH_DUTY0 && reg_addr < ADDR_CH_DUTY0 + 8'h10) begin
            s_nxt.rdata = s_r.duty[8*(reg_addr - ADDR_CH_DUTY0) +: 8];
        end else if (reg_addr >= ADDR_CH_GAIN0 && reg_addr < ADDR_CH_GAIN0 + 8'h10) begin
            s_nxt.rdata = s_r.gain[8*(reg_addr - ADDR_CH_GAIN0) +: 8];
        end else if (reg_addr >= ADDR_DRIVE_MODE0 && reg_addr < ADDR_DRIVE_MODE0 + 8'h04) begin
            s_nxt.rdata = s_r.drive_mode[8*(reg_addr - ADDR_DRIVE_MODE0) +: 8];
        end else begin
            case (reg_addr)
                ADDR_FIRST_MODE: s_nxt.rdata = s_r.first_mode;
                ADDR_SECOND_MODE: s_nxt.rdata = {thermal, s_r.test_busy, 6'h00};
                ADDR_BCAST_ADDR: s_nxt.rdata = {s_r.bcast_addr, 1'b0};
                ADDR_FLAGS_LOW: s_nxt.rdata = s_r.flags[7:0];
                ADDR_FLAGS_HIGH: s_nxt.rdata = s_r.flags[15:8];
                default: s_nxt.rdata = 8'h00;
            endcase
        end

        // fault test: one 1.25 us slot per channel, 16 slots = 20 us < 52 us
        case (s_r.st)
            IDLE: ;
            TESTING: begin
                if (s_r.step == STEP_LAST) begin
                    s_nxt.step = '0;
                    if (active_ch[s_r.chan]) begin
                        s_nxt.open_acc[s_r.chan] = s_r.open_s2[s_r.chan];
                        s_nxt.short_acc[s_r.chan] = s_r.short_s2[s_r.chan];
                    end
                    if (s_r.chan == 4'hF) begin
                        s_nxt.st = HOLD_OFF;
                        s_nxt.test_busy = 1'b0;
                        // opens take precedence over shorts
                        if (s_nxt.open_acc != 16'h0000) begin
                            s_nxt.flags = s_nxt.open_acc & active_ch;
                        end else begin
                            s_nxt.flags = s_nxt.short_acc & active_ch;
                        end
                    end else begin
                        s_nxt.chan = s_r.chan + 4'h1;
                    end
                end else begin
                    s_nxt.step = s_r.step + STEP_W'(1);
                end
            end
            HOLD_OFF: begin
                // outputs stay off until the next register access
                if (reg_wr || reg_rd) begin
                    s_nxt.st = IDLE;
                end
            end
            default: s_nxt.st = IDLE;
        endcase

        // broadcast address acknowledge
        s_nxt.match = bus_addr_valid && s_r.first_mode[BIT_BCAST_ACK]
                      && bus_addr == s_r.bcast_addr;

        // output enables; gain code passes straight to the linear current dac
        for (int i = 0; i < CHANNELS; i++) begin
            s_nxt.en[i] = active_ch[i] && s_r.st == IDLE && !thermal;
            s_nxt.pwm[i] = s_r.drive_mode[2*i + 1];
            s_nxt.tdrv[i] = s_r.st == TESTING && s_r.chan == 4'(i)
                            && active_ch[i] && !thermal;
        end
    end

    // state register; prior output state returns once thermal clears
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            s_r <= '0;
            s_r.first_mode <= FIRST_MODE_RESET;
            s_r.bcast_addr <= BCAST_ADDR_RESET[7:1];
            s_r.st <= IDLE;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign reg_rdata = s_r.rdata;
    assign broadcast_match = s_r.match;
    assign chan_enable = s_r.en;
    assign chan_pwm_mode = s_r.pwm;
    assign chan_test_drive = s_r.tdrv;
    assign chan_duty_bus = s_r.duty;
    assign chan_gain_bus = s_r.gain;

    // test bit drops within the 52 us bound
    int unsigned busy_cnt;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            busy_cnt <= 0;
        end else begin
            busy_cnt <= s_r.test_busy ? busy_cnt + 1 : 0;
        end
    end

    property p_test_time;
        @(posedge clk) disable iff (rst) busy_cnt <= TOTAL_CYCLES;
    endproperty
    a_test_time: assert property (p_test_time) else $error("fault test too long");

    property p_start;
        @(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_SECOND_MODE && reg_wdata[BIT_FAULT_TEST]
         && s_r.st == IDLE) |=> s_r.test_busy ##1 (chan_enable == 16'h0000);
    endproperty
    a_start: assert property (p_start) else $error("test did not start");

    property p_off_during;
        @(posedge clk) disable iff (rst) (s_r.st != IDLE) |=> chan_enable == 16'h0000;
    endproperty
    a_off_during: assert property (p_off_during) else $error("output on in test");

    property p_bduty;
        @(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_BCAST_DUTY) |=> chan_duty_bus == {16{$past(reg_wdata)}};
    endproperty
    a_bduty: assert property (p_bduty) else $error("broadcast duty lost");

    property p_bgain;
        @(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_BCAST_GAIN) |=> chan_gain_bus == {16{$past(reg_wdata)}};
    endproperty
    a_bgain: assert property (p_bgain) else $error("broadcast gain lost");

    property p_unused_zero;
        @(posedge clk) disable iff (rst)
        $fell(s_r.test_busy) |-> (s_r.flags & ~active_ch) == 16'h0000;
    endproperty
    a_unused_zero: assert property (p_unused_zero) else $error("unused flagged");

    property p_thermal;
        @(posedge clk) disable iff (rst) thermal |=> chan_enable == 16'h0000;
    endproperty
    a_thermal: assert property (p_thermal) else $error("output on when hot");

    property p_ack_off;
        @(posedge clk) disable iff (rst)
        !s_r.first_mode[BIT_BCAST_ACK] |=> !broadcast_match;
    endproperty
    a_ack_off: assert property (p_ack_off) else $error("acked while disabled");

    property p_addr_lsb;
        @(posedge clk) disable iff (rst)
        (reg_addr == ADDR_BCAST_ADDR) |=> reg_rdata[0] == 1'b0;
    endproperty
    a_addr_lsb: assert property (p_addr_lsb) else $error("address lsb set");

    // single duty write lands on its own channel, neighbour untouched
    property p_single_duty;
        @(posedge clk) disable iff (rst)
        (reg_wr && reg_addr == ADDR_CH_DUTY0 + 8'h05) |=>
            chan_duty_bus[47:40] == $past(reg_wdata)
            && chan_duty_bus[39:32] == $past(chan_duty_bus[39:32]);
    endproperty
    a_single_duty: assert property (p_single_duty) else $error("duty write lost");

    // test drive only ever comes from the test slot logic
    property p_idle_no_drive;
        @(posedge clk) disable iff (rst) (s_r.st != TESTING) |=> chan_test_drive == 16'h0000;
    endproperty
    a_idle_no_drive: assert property (p_idle_no_drive) else $error("drive outside test");

    // host writes to the flag registers must not disturb them
    property p_flags_ro;
        @(posedge clk) disable iff (rst)
        (reg_wr && (reg_addr == ADDR_FLAGS_LOW || reg_addr == ADDR_FLAGS_HIGH)
         && s_r.st == IDLE) |=> $stable(s_r.flags);
    endproperty
    a_flags_ro: assert property (p_flags_ro) else $error("flags written by host");
endmodule : led_fault_test_and_broadcast_ctrl

// ==== dv/led_host_model.sv ====
// register-side host model standing in for the serial bus master
`timescale 1ns/1ps
module led_host_model (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata
);
    // bus idle at time zero
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
    end
    // one write, launched off the falling edge, taken at the next rise
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_wr = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_wdata = ~d; // stale data never looks valid
    endtask : wr
    // address held over one rise, answer picked up at the next fall
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_rd = 1'b1;
        reg_addr = a;
        @(negedge clk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask : rd
endmodule : led_host_model

// ==== dv/led_fault_test_and_broadcast_ctrl_tb_top.sv ====
// self-checking bench for the led fault test and broadcast control block
`timescale 1ns/1ps
module led_fault_test_and_broadcast_ctrl_tb_top;
    import led_ctrl_pkg::*;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, bus_addr_valid, broadcast_match, thermal_shutdown_flag_det;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [6:0] bus_addr;
    logic [15:0] open_det, short_det, chan_enable, chan_pwm_mode, chan_test_drive;
    logic [127:0] chan_duty_bus, chan_gain_bus;
    int errors = 0;
    int tests_run = 0;

    always #25 clk = ~clk;

    led_host_model host (.clk(clk), .reg_rdata(reg_rdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata));
    led_fault_test_and_broadcast_ctrl dut (.clk(clk), .rst(rst), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .bus_addr(bus_addr), .bus_addr_valid(bus_addr_valid),
        .broadcast_match(broadcast_match), .open_det(open_det), .short_det(short_det),
        .thermal_shutdown_flag_det(thermal_shutdown_flag_det), .chan_enable(chan_enable),
        .chan_pwm_mode(chan_pwm_mode), .chan_test_drive(chan_test_drive),
        .chan_duty_bus(chan_duty_bus), .chan_gain_bus(chan_gain_bus));

    task automatic results;
        $display("checks %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : results

    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            errors++;
            $display("ERROR %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // reset values, address masking and the acknowledge enable
    task automatic t_broadcast_ack_enable;
        logic [7:0] d;
        host.rd(ADDR_FIRST_MODE, d);
        chk("first mode", {8'h00, FIRST_MODE_RESET}, {8'h00, d});
        host.wr(ADDR_FLAGS_LOW, 8'hFF);
        host.rd(ADDR_FLAGS_LOW, d);
        chk("flags read-only", 16'h0000, {8'h00, d});
        host.wr(ADDR_BCAST_ADDR, 8'hFF);
        host.rd(ADDR_BCAST_ADDR, d);
        chk("bcast addr", 16'h00FE, {8'h00, d});
        for (int k = 0; k < 2; k++) begin
            @(negedge clk);
            bus_addr = 7'h7F;
            bus_addr_valid = 1'b1;
            repeat (2) @(negedge clk);
            chk("bcast match", {15'h0000, ~k[0]}, {15'h0000, broadcast_match});
            bus_addr_valid = 1'b0;
            host.wr(ADDR_FIRST_MODE, 8'h00);
        end
    endtask : t_broadcast_ack_enable

    // broadcast duty then gain, one channel overridden afterwards
    task automatic t_bcast;
        logic [7:0] d;
        logic [7:0] base;
        for (int k = 0; k < 2; k++) begin
            base = k ? ADDR_CH_GAIN0 : ADDR_CH_DUTY0;
            host.wr(k ? ADDR_BCAST_GAIN : ADDR_BCAST_DUTY, 8'hA5 + k[7:0]);
            host.wr(base + 8'h05, 8'h3C);
            for (int c = 0; c < CHANNELS; c++) begin
                host.rd(base + c[7:0], d);
                chk("channel", (c == 5) ? 16'h003C : 16'h00A5 + k[15:0], {8'h00, d});
            end
            host.rd(k ? ADDR_BCAST_GAIN : ADDR_BCAST_DUTY, d);
            chk("write-only", 16'h0000, {8'h00, d});
        end
        chk("gain bus", 16'h003C, {8'h00, chan_gain_bus[47:40]});
        chk("duty bus", 16'h3CA5, {chan_duty_bus[47:40], chan_duty_bus[7:0]});
    endtask : t_bcast

    // one fault test with given detector levels
    task automatic run_test(input logic [15:0] op, input logic [15:0] sh, input logic [15:0] e);
        logic [7:0] d;
        int n;
        @(negedge clk);
        open_det = op;
        short_det = sh;
        host.wr(ADDR_SECOND_MODE, 8'h40);
        repeat (3) @(negedge clk);
        chk("outputs off", 16'h0000, chan_enable);
        // channel 0 is off, so the second slot drives channel 1
        repeat (25) @(negedge clk);
        chk("test drive", 16'h0002, chan_test_drive);
        d = 8'hFF;
        n = 0;
        while (d[BIT_FAULT_TEST] !== 1'b0 && n < TOTAL_CYCLES / 2) begin
            host.rd(ADDR_SECOND_MODE, d);
            n++;
        end
        chk("test done", 16'h0000, {15'h0000, d[BIT_FAULT_TEST]});
        if (d[BIT_FAULT_TEST] !== 1'b0) begin
            results();
        end else begin
            host.rd(ADDR_FLAGS_LOW, d);
            chk("flags low", {8'h00, e[7:0]}, {8'h00, d});
            host.rd(ADDR_FLAGS_HIGH, d);
            chk("flags high", {8'h00, e[15:8]}, {8'h00, d});
        end
    endtask : run_test

    // thermal shutdown raised and released
    task automatic t_thermal;
        logic [7:0] d;
        for (int k = 1; k >= 0; k--) begin
            @(negedge clk);
            thermal_shutdown_flag_det = k[0];
            repeat (4) @(negedge clk);
            host.rd(ADDR_SECOND_MODE, d);
            chk("thermal flag", {15'h0000, k[0]}, {15'h0000, d[BIT_THERMAL]});
            if (k == 1) begin
                chk("outputs off hot", 16'h0000, chan_enable);
            end else begin
                chk("outputs restored", 16'hFFFE, chan_enable);
            end
        end
    endtask : t_thermal

    initial begin
        bus_addr = 7'h00;
        bus_addr_valid = 1'b0;
        open_det = 16'h0000;
        short_det = 16'h0000;
        thermal_shutdown_flag_det = 1'b0;
        repeat (4) @(negedge clk);
        rst = 1'b0;
        t_broadcast_ack_enable();
        t_bcast();
        // channel 0 off, the rest individual dimming
        host.wr(ADDR_DRIVE_MODE0, 8'hA8);
        for (int r = 1; r < 4; r++) begin
            host.wr(ADDR_DRIVE_MODE0 + r[7:0], 8'hAA);
        end
        @(negedge clk);
        chk("pwm mode", 16'hFFFE, chan_pwm_mode);
        run_test(16'h0009, 16'h0200, 16'h0008);
        run_test(16'h0000, 16'h0201, 16'h0200);
        run_test(16'h0000, 16'h0000, 16'h0000);
        t_thermal();
        results();
    end
endmodule : led_fault_test_and_broadcast_ctrl_tb_top
